//--- hdl/sfcl_pkg.sv
package sfcl_pkg;
  // ---------------------------------------------------------------
  // word layout
  // ---------------------------------------------------------------
  localparam int WORD_W = 24;
  localparam int POS_SEL_LOW = 0;
  localparam int POS_SEL_HIGH = 1;
  localparam int POS_COUNTER_HOLD = 2;
  localparam int POS_PD_REQUEST = 3;
  localparam int POS_MON_LSB = 4;
  localparam int POS_MON_MSB = 6;
  localparam int POS_PHASE_POL = 7;
  localparam int POS_PUMP_TRISTATE = 8;
  localparam int POS_FASTLOCK_ON = 9;
  localparam int POS_FASTLOCK_MODE = 10;
  localparam int POS_TIMEOUT_LSB = 11;
  localparam int POS_TIMEOUT_MSB = 14;
  localparam int POS_BASE_LSB = 15;
  localparam int POS_BASE_MSB = 17;
  localparam int POS_BOOST_LSB = 18;
  localparam int POS_BOOST_MSB = 20;
  localparam int POS_PD_SYNC = 21;
  localparam int POS_PRESC_LSB = 22;
  localparam int POS_PRESC_MSB = 23;
  // pump gain bit inside the counter word
  localparam int POS_AB_GAIN = 21;

  // ---------------------------------------------------------------
  // codes and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_COUNTER_AB = 2'h1;
  localparam logic [1:0] SEL_FUNCTION = 2'h2;
  localparam logic [1:0] SEL_INIT = 2'h3;
  // counters held and pump tristated until the host programs the word
  localparam logic [23:0] FUNC_RESET = 24'h000104;
  // timeout step in phase detector cycles per code
  localparam int TIMEOUT_STEP = 4;
  localparam int TIMEOUT_BASE = 3;

  typedef enum logic [1:0] {
    SFCL_FL_IDLE = 2'b00,
    SFCL_FL_BOOST = 2'b01,
    SFCL_FL_TIMED = 2'b10
  } sfcl_fl_type;
endpackage

//--- hdl/sfcl_function_latch.sv
`timescale 1ns/1ps
// What this block does
// [RL1] load the function word only when select bits read high 1, low 0
// [RL2] counter hold bit at one keeps reference and AB counters in reset
// [RL3] hold release restarts feedback divider aligned with reference counter
// [RL4] host keeps counter hold at zero normally, clears it after power-up
// [RL5] chip enable low powers down at once; power-down bits need it high
// [RL6] request one with sync select zero powers down when word latches
// [RL7] request and sync select both one waits for next pump event
// [RL8] any power-down puts reference, feedback and timeout counters at load
// [RL9] any power-down tristates the charge pump output
// [RL10] any power-down resets digital lock detect
// [RL11] any power-down disables reference buffer and RF input bias
// [RL12] serial input register keeps shifting and latching in power-down
// [RL13] three-bit monitor select field picks the monitor output signal
// [RL14] fastlock acts only while fastlock enable bit is one
// [RL15] mode bit zero selects fastlock mode 1, one selects mode 2
// [RL16] pump gain one in either mode switches pump to boost current
// [RL17] mode 1 leaves fastlock only when host writes pump gain zero
// [RL18] mode 2 clears pump gain itself after the selected timeout
// [RL19] timeout comes from the four-bit timeout field
// [RL20] base current from low three current bits, boost from upper three
// [RL21] pump tristate bit one tristates the pump, zero enables it; the code also tristates it while counter hold is one
// [RL22] fastlock disabled always drives base current
// [RL23] other select codes leave the function word unchanged
module sfcl_function_latch
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic serialLatch,
  input wire logic chipEnable,
  input wire logic pumpEvent,
  input wire logic pfdTick,
  input wire logic [7:0] monitorSources,
  output logic [sfcl_pkg::WORD_W-1:0] functionWord,
  output logic counterReset,
  output logic powerDown,
  output logic pumpTristate,
  output logic lockDetectReset,
  output logic refBufferEnable,
  output logic rfBiasEnable,
  output logic [2:0] pumpCurrent,
  output logic pumpGain,
  output logic phasePolarity,
  output logic [1:0] prescalerSelect,
  output logic monitor_output_pin
);
  import sfcl_pkg::*;

  // ---------------------------------------------------------------
  // serial input register
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] shiftReg;
  logic prevClk;
  logic prevLatch;
  logic shiftEdge;
  logic latchEdge;
  logic [1:0] selCode;
  logic [WORD_W-1:0] fw;
  logic pdActive;
  logic gainBit;
  logic [5:0] timer;
  logic [5:0] next_timer;
  sfcl_fl_type flState;

  assign shiftEdge = serialClk & ~prevClk;
  assign latchEdge = serialLatch & ~prevLatch;
  assign selCode = shiftReg[POS_SEL_HIGH:POS_SEL_LOW];

  // edge tracking; pins are synchronous to ref_clk
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      prevClk <= 1'b0;
      prevLatch <= 1'b0;
    end
    else
    begin
      prevClk <= serialClk;
      prevLatch <= serialLatch;
    end
  end

  // shifting is never gated by power-down so words load at any time
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      shiftReg <= '0;
    else if (shiftEdge)
      shiftReg <= {shiftReg[WORD_W-2:0], serialData}; // [RL12]
  end

  // ---------------------------------------------------------------
  // function word
  // ---------------------------------------------------------------
  // only the function code loads this word; init words are not taken here
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      fw <= FUNC_RESET;
    else if (latchEdge && selCode == SEL_FUNCTION)
      fw <= shiftReg; // [RL1] [RL23]
  end
  assign functionWord = fw;

  // ---------------------------------------------------------------
  // power-down
  // ---------------------------------------------------------------
  // async request takes effect as the word latches; sync waits for pump
  // a pump event seen while the pin is low still arms a sync request
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      pdActive <= 1'b0;
    else if (!fw[POS_PD_REQUEST])
      pdActive <= 1'b0;
    else if (!fw[POS_PD_SYNC])
      pdActive <= 1'b1; // [RL6]
    else if (pumpEvent)
      pdActive <= 1'b1; // [RL7]
  end

  // pin low overrides whatever the power-down bits hold
  logic pdNow;
  assign pdNow = !chipEnable || pdActive; // [RL5]

  // analog enables and resets, all registered
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      powerDown <= 1'b1;
      counterReset <= 1'b1;
      pumpTristate <= 1'b1;
      lockDetectReset <= 1'b1;
      refBufferEnable <= 1'b0;
      rfBiasEnable <= 1'b0;
    end
    else
    begin
      powerDown <= pdNow;
      // hold release frees both counters on the same edge for alignment
      counterReset <= pdNow || fw[POS_COUNTER_HOLD]; // [RL2] [RL3] [RL8]
      pumpTristate <= pdNow || fw[POS_PUMP_TRISTATE] ||
        fw[POS_COUNTER_HOLD]; // [RL9] [RL21]
      lockDetectReset <= pdNow; // [RL10]
      refBufferEnable <= !pdNow; // [RL11]
      rfBiasEnable <= !pdNow; // [RL11]
    end
  end

  // ---------------------------------------------------------------
  // fastlock and pump gain
  // ---------------------------------------------------------------
  // AB words only carry the pump gain bit as far as this block cares
  logic abLoad;
  assign abLoad = latchEdge && selCode == SEL_COUNTER_AB;

  // host writes set or clear gain; timer expiry clears it in mode 2
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      gainBit <= 1'b0;
    else if (abLoad)
      gainBit <= shiftReg[POS_AB_GAIN]; // [RL16] [RL17]
    else if (flState == SFCL_FL_TIMED && pfdTick && timer == 6'h00)
      gainBit <= 1'b0; // [RL18]
  end

  // timeout load is (code*4+3) phase detector cycles
  always_comb
  begin
    next_timer = 6'(TIMEOUT_BASE) +
      6'(TIMEOUT_STEP) * 6'(fw[POS_TIMEOUT_MSB:POS_TIMEOUT_LSB]); // [RL19]
  end

  // reloaded while idle so a new timeout field applies to the next boost
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      flState <= SFCL_FL_IDLE;
      timer <= '0;
    end
    else if (pdNow || !fw[POS_FASTLOCK_ON])
    begin
      flState <= SFCL_FL_IDLE; // [RL8] [RL14]
      timer <= next_timer;
    end
    else
    begin
      case (flState)
        SFCL_FL_IDLE:
        begin
          timer <= next_timer;
          if (abLoad && shiftReg[POS_AB_GAIN])
            flState <= fw[POS_FASTLOCK_MODE] ? SFCL_FL_TIMED
              : SFCL_FL_BOOST; // [RL15]
        end
        SFCL_FL_BOOST:
          if (!gainBit)
            flState <= SFCL_FL_IDLE; // [RL17]
        SFCL_FL_TIMED:
          if (!gainBit)
            flState <= SFCL_FL_IDLE;
          else if (pfdTick && timer != 6'h00)
            timer <= timer - 6'h01; // [RL18]
        default:
          flState <= SFCL_FL_IDLE;
      endcase
    end
  end

  // boost current only while fastlock is on and gain is set
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pumpCurrent <= '0;
      pumpGain <= 1'b0;
    end
    else
    begin
      pumpGain <= gainBit;
      if (fw[POS_FASTLOCK_ON] && gainBit)
        pumpCurrent <= fw[POS_BOOST_MSB:POS_BOOST_LSB]; // [RL16] [RL20]
      else
        pumpCurrent <= fw[POS_BASE_MSB:POS_BASE_LSB]; // [RL22] [RL20]
    end
  end

  // ---------------------------------------------------------------
  // monitor output and misc fields
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      monitor_output_pin <= 1'b0;
      phasePolarity <= 1'b0;
      prescalerSelect <= '0;
    end
    else
    begin
      monitor_output_pin <= monitorSources[fw[POS_MON_MSB:POS_MON_LSB]];
      // [RL13] source index from the select field
      phasePolarity <= fw[POS_PHASE_POL];
      prescalerSelect <= fw[POS_PRESC_MSB:POS_PRESC_LSB];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // word loading and the serial register
  AST_LOAD_CODE: assert property ( // [RL1]
    @(posedge ref_clk) disable iff (rst)
    latchEdge && selCode == SEL_FUNCTION |=> fw == $past(shiftReg))
    else $error("function word not loaded");
  AST_KEEP_OTHER: assert property ( // [RL23]
    @(posedge ref_clk) disable iff (rst)
    latchEdge && selCode != SEL_FUNCTION |=> $stable(fw))
    else $error("function word changed on other code");
  AST_SHIFT_PD: assert property ( // [RL12]
    @(posedge ref_clk) disable iff (rst)
    powerDown && shiftEdge |=> shiftReg[0] == $past(serialData))
    else $error("serial register stopped in power-down");

  // counters, pump and power-down
  AST_HOLD: assert property ( // [RL2]
    @(posedge ref_clk) disable iff (rst)
    fw[POS_COUNTER_HOLD] |=> counterReset)
    else $error("counters not held");
  AST_RELEASE: assert property ( // [RL3]
    @(posedge ref_clk) disable iff (rst)
    !pdNow && !fw[POS_COUNTER_HOLD] |=> !counterReset)
    else $error("counters not released together");
  AST_CE_LOW: assert property ( // [RL5]
    @(posedge ref_clk) disable iff (rst)
    !chipEnable |=> powerDown && pumpTristate && lockDetectReset)
    else $error("chip enable low did not power down");
  AST_ASYNC_PD: assert property ( // [RL6]
    @(posedge ref_clk) disable iff (rst)
    chipEnable && fw[POS_PD_REQUEST] && !fw[POS_PD_SYNC] ##1 chipEnable
    |=> powerDown)
    else $error("async power-down late");
  AST_SYNC_WAIT: assert property ( // [RL7]
    @(posedge ref_clk) disable iff (rst)
    fw[POS_PD_SYNC] && !pdActive && !pumpEvent |=> !pdActive)
    else $error("sync power-down before pump event");
  AST_PD_ANALOG: assert property ( // [RL8] [RL11]
    @(posedge ref_clk) disable iff (rst)
    powerDown |-> !refBufferEnable && !rfBiasEnable && counterReset)
    else $error("analog not off in power-down");
  AST_PD_PUMP_LOCK: assert property ( // [RL9] [RL10]
    @(posedge ref_clk) disable iff (rst)
    powerDown |-> pumpTristate && lockDetectReset)
    else $error("pump or lock detect active in power-down");
  AST_PD_COUNTERS: assert property ( // [RL8]
    @(posedge ref_clk) disable iff (rst)
    pdNow |=> counterReset && flState == SFCL_FL_IDLE)
    else $error("counters not at load in power-down");
  AST_LOCK_FREE: assert property ( // [RL10]
    @(posedge ref_clk) disable iff (rst)
    !pdNow |=> !lockDetectReset)
    else $error("lock detect held while powered up");
  AST_TRISTATE: assert property ( // [RL21]
    @(posedge ref_clk) disable iff (rst)
    fw[POS_PUMP_TRISTATE] |=> pumpTristate)
    else $error("pump not tristated");
  AST_PUMP_ON: assert property ( // [RL21]
    @(posedge ref_clk) disable iff (rst)
    !pdNow && !fw[POS_PUMP_TRISTATE] && !fw[POS_COUNTER_HOLD]
    |=> !pumpTristate)
    else $error("pump left tristated");

  // fastlock
  AST_OFF_IDLE: assert property ( // [RL14]
    @(posedge ref_clk) disable iff (rst)
    !fw[POS_FASTLOCK_ON] |=> flState == SFCL_FL_IDLE)
    else $error("fastlock active while disabled");
  AST_PICK_MODE1: assert property ( // [RL15]
    @(posedge ref_clk) disable iff (rst)
    flState == SFCL_FL_IDLE && !pdNow && fw[POS_FASTLOCK_ON] &&
    abLoad && shiftReg[POS_AB_GAIN] && !fw[POS_FASTLOCK_MODE]
    |=> flState == SFCL_FL_BOOST)
    else $error("fastlock mode 1 not entered");
  AST_PICK_MODE2: assert property ( // [RL15]
    @(posedge ref_clk) disable iff (rst)
    flState == SFCL_FL_IDLE && !pdNow && fw[POS_FASTLOCK_ON] &&
    abLoad && shiftReg[POS_AB_GAIN] && fw[POS_FASTLOCK_MODE]
    |=> flState == SFCL_FL_TIMED)
    else $error("fastlock mode 2 not entered");
  AST_MODE1_STAY: assert property ( // [RL17]
    @(posedge ref_clk) disable iff (rst)
    flState == SFCL_FL_BOOST && gainBit && !abLoad |=> gainBit)
    else $error("mode 1 left without a host write");
  AST_TIMER_LOAD: assert property ( // [RL19]
    @(posedge ref_clk) disable iff (rst)
    flState == SFCL_FL_IDLE |=> timer == $past(next_timer))
    else $error("timer not loaded from timeout field");
  AST_TIMEOUT: assert property ( // [RL18]
    @(posedge ref_clk) disable iff (rst)
    flState == SFCL_FL_TIMED && pfdTick && timer == 6'h00 && !abLoad
    |=> !gainBit)
    else $error("pump gain not cleared at timeout");
  AST_BASE_WHEN_OFF: assert property ( // [RL22]
    @(posedge ref_clk) disable iff (rst)
    !fw[POS_FASTLOCK_ON] ##1 $stable(fw)
    |-> pumpCurrent == fw[POS_BASE_MSB:POS_BASE_LSB])
    else $error("boost used with fastlock off");
  AST_BOOST: assert property ( // [RL16] [RL20]
    @(posedge ref_clk) disable iff (rst)
    fw[POS_FASTLOCK_ON] && gainBit ##1 $stable(fw)
    |-> pumpCurrent == fw[POS_BOOST_MSB:POS_BOOST_LSB])
    else $error("boost current not applied");
endmodule

//--- tb/sfcl_host_model.sv
`timescale 1ns/1ps
// host side of the three-wire port: shifts one word in, msb first
module sfcl_host_model
(
  input wire logic ref_clk,
  input wire logic go,
  input wire logic [23:0] word,
  output logic busy,
  output logic serialClk,
  output logic serialData,
  output logic serialLatch
);
  logic [23:0] w;

  // quiet lines until the first word
  initial
  begin
    busy = 1'b0;
    serialClk = 1'b0;
    serialData = 1'b0;
    serialLatch = 1'b0;
  end

  // two cycles per bit so the sampled clock always shows both levels;
  // the data line is flipped once released so stale bits never look valid
  always
  begin
    @(posedge ref_clk iff go);
    #1 busy = 1'b1;
    w = word;
    for (int i = 23; i >= 0; i--)
    begin
      serialData = w[i];
      @(posedge ref_clk) #1 serialClk = 1'b1;
      @(posedge ref_clk) #1 serialClk = 1'b0;
    end
    serialData = ~serialData;
    serialLatch = 1'b1;
    @(posedge ref_clk) #1 serialLatch = 1'b0;
    busy = 1'b0;
  end
endmodule

//--- tb/sfcl_function_latch_bench.sv
`timescale 1ns/1ps
module sfcl_function_latch_bench;
  import sfcl_pkg::*;
  typedef struct {int k; logic [23:0] e; logic [23:0] m;} sfcl_note_type;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic chipEnable = 1'b1;
  logic pumpEvent = 1'b0;
  logic pfdTick = 1'b0;
  logic go = 1'b0;
  logic busy, serialClk, serialData, serialLatch;
  logic [7:0] monitorSources = 8'h00;
  logic [WORD_W-1:0] word = 24'h000000;
  logic [WORD_W-1:0] expWord = 24'h000104;
  logic [WORD_W-1:0] functionWord;
  logic counterReset, powerDown, pumpTristate, lockDetectReset;
  logic refBufferEnable, rfBiasEnable, pumpGain, phasePolarity, monitorPin;
  logic [2:0] pumpCurrent;
  logic [1:0] prescalerSelect;
  int seed = 32'hEBDF8E4B;
  int badCount = 0;
  int checkCount = 0;
  int cycles = 0;
  sfcl_note_type notes[$];
  event chk;

  always #10 ref_clk = ~ref_clk;

  sfcl_function_latch dut_u
  (
    .ref_clk, .rst, .serialClk, .serialData, .serialLatch, .chipEnable,
    .pumpEvent, .pfdTick, .monitorSources, .functionWord, .counterReset,
    .powerDown, .pumpTristate, .lockDetectReset, .refBufferEnable,
    .rfBiasEnable, .pumpCurrent, .pumpGain, .phasePolarity,
    .prescalerSelect, .monitor_output_pin(monitorPin)
  );

  sfcl_host_model host_u
  (
    .ref_clk, .go, .word, .busy, .serialClk, .serialData, .serialLatch
  );

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [23:0] e, input logic [23:0] a);
    checkCount++;
    if (a !== e)
    begin
      badCount++;
      $display("Error at %0t: expected %h got %h", $time, e, a);
    end
  endtask

  // one compare per kind of result
  task automatic cmp_word(input logic [23:0] e);
    check(e, functionWord);
  endtask

  task automatic cmp_power(input logic [23:0] e, input logic [23:0] m);
    check(e, m & 24'({powerDown, counterReset, pumpTristate,
      lockDetectReset, refBufferEnable, rfBiasEnable}));
  endtask

  task automatic cmp_pump(input logic [23:0] e);
    check(e, 24'({pumpCurrent, pumpGain}));
  endtask

  task automatic cmp_monitor(input logic [23:0] e);
    check(e, 24'(monitorPin));
  endtask

  task automatic cmp_fields(input logic [23:0] e);
    check(e, 24'({prescalerSelect, phasePolarity}));
  endtask

  task automatic note(input int k, input logic [23:0] e, input logic [23:0] m);
    notes.push_back(sfcl_note_type'{k, e, m});
    -> chk;
  endtask

  // power status is masked: some fields are free in some states
  task automatic pwr(input logic [5:0] e, input logic [5:0] m);
    note(1, 24'(e), 24'(m));
  endtask

  task automatic pump(input logic [3:0] e);
    note(2, 24'(e), 24'hFFFFFF);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic ticks(input int n);
    repeat (n)
    begin
      pfdTick = 1'b1;
      cyc(1);
      pfdTick = 1'b0;
      cyc(1);
    end
  endtask

  // only the function code replaces the expected word; others leave it
  task automatic send(input logic [23:0] w);
    word = w;
    go = 1'b1;
    @(posedge busy);
    go = 1'b0;
    @(negedge busy);
    cyc(3);
    if (w[1:0] == SEL_FUNCTION)
      expWord = w;
    note(0, expWord, 24'hFFFFFF);
  endtask

  // result side: drains notes oldest first against the live outputs
  always @(chk)
    while (notes.size() > 0)
    begin
      case (notes[0].k)
        0: cmp_word(notes[0].e);
        1: cmp_power(notes[0].e, notes[0].m);
        2: cmp_pump(notes[0].e);
        3: cmp_monitor(notes[0].e);
        default: cmp_fields(notes[0].e);
      endcase
      void'(notes.pop_front());
    end

  // hang guard: the whole sequence needs under 3000 cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      badCount++;
      report_and_stop();
    end
  end

  // base current 5 and boost current 2 in every function word below
  initial
  begin
    cyc(10);
    rst = 1'b0;
    note(0, 24'h000104, 24'hFFFFFF);
    pwr(6'h3C, 6'h3F);
    send(24'h0A8006);
    pwr(6'h18, 6'h38);
    send(24'h0A8002);
    pwr(6'h03, 6'h3F);
    send(24'hCA8082);
    note(4, 24'h000007, 24'hFFFFFF);
    pump(4'hA);
    send(24'h200001);
    pump(4'hB);
    send(24'($random(seed)) & 24'hFFFFFC);
    for (int m = 0; m < 8; m++)
    begin
      monitorSources = 8'($random(seed));
      send(24'h0A8002 | 24'(m << 4));
      note(3, 24'(monitorSources[m]), 24'h000001);
    end
    send(24'h0A8202);
    send(24'h200001);
    ticks(20);
    pump(4'h5);
    send(24'h000001);
    pump(4'hA);
    send(24'h0A8E02);
    send(24'h200001);
    ticks(7);
    pump(4'h5);
    ticks(1);
    pump(4'hA);
    send(24'h0A800A);
    pwr(6'h3C, 6'h3F);
    send(24'h0A8002);
    pwr(6'h03, 6'h3F);
    send(24'h2A800A);
    pwr(6'h00, 6'h20);
    pumpEvent = 1'b1;
    cyc(1);
    pumpEvent = 1'b0;
    cyc(3);
    pwr(6'h3C, 6'h3F);
    send(24'h0A8003);
    send(24'h0A8002);
    chipEnable = 1'b0;
    cyc(2);
    pwr(6'h3C, 6'h3F);
    chipEnable = 1'b1;
    cyc(3);
    pwr(6'h03, 6'h3F);
    report_and_stop();
  end
endmodule
